// ===== pkg/ctc_params.svh
// Contract
// [R01] The write after a control word announcing it is the time constant.
// [R02] Eight-bit time constant per channel; zero means a count of 256.
// [R03] A new time constant on a running channel waits for zero before reload.
// [R04] Acknowledge returns a vector byte unique to the requesting channel.
// [R05] Upper five vector bits are written via channel 0 and shared.
// [R06] A written word with bit 0 clear loads the vector register.
// [R07] Vector bits 2-1 carry the requesting channel number.
// [R08] Write is read strobe high with request and chip enable low.
// [R09] The two select inputs pick the channel of each access.
// [R10] Written words are latched on the edge that begins T3.
// [R11] The host keeps opcode fetch inactive for register accesses.
// [R12] A read returns the channel down-counter at T3, without waits.
// [R13] Counter mode decrements on each selected trigger edge, clock synchronous.
// [R14] The host keeps trigger pulses wide and at least two clocks apart.
// [R15] A trigger edge too near a clock edge slips the decrement one clock.
// [R16] The zero-count output pulses right after the counter steps 1 to 0.
// [R17] Timer trigger starts timing on the second following clock edge.
// [R18] Each channel may request an interrupt at every zero count.
// [R19] Chain enable in and out set priority between devices.
// [R20] Channel 0 has highest priority, channel 3 lowest.
// [R21] Lower priority never interrupts a higher one still under service.
// [R22] Vector driven only with chain enable in, for the top requester.
// [R23] Return opcode pair re-initialises the serviced channel and its chain.
// [R24] A written word with bit 0 set is the channel control word.
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH
`define CTL_VECTOR_BIT 0
`define CTL_SW_RESET 1
`define CTL_TC_FOLLOWS 2
`define CTL_TRIGGERED 3
`define CTL_RISING 4
`define CTL_PRE256 5
`define CTL_COUNTER 6
`define CTL_IRQ_EN 7
`define VEC_BASE_MSB 7
`define VEC_BASE_LSB 3
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define BYTE_ALL 8'hff
`define PRE16_LAST 8'h0f
`define PRE256_LAST 8'hff
`define OP_PREFIX 8'hed
`define OP_RETURN 8'h4d
`endif

// ===== pkg/ctc_pkg.sv
package ctc_pkg;
  typedef struct packed {
    logic io_request_n;
    logic chip_enable_n;
    logic read_n;
    logic opcode_fetch_n;
    logic channel_select_hi;
    logic channel_select_lo;
    logic [7:0] data;
  } host_bus_t;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_ARMED = 2'b01,
    CH_START = 2'b11,
    CH_RUN = 2'b10
  } chan_state_t;
endpackage : ctc_pkg

// ===== src/counter_timer_unit.sv
`timescale 1ns/10ps
`include "ctc_params.svh"
module counter_timer_unit #(
  parameter int NUM_CH = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire ctc_pkg::host_bus_t host_bus,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [NUM_CH-1:0] external_count_trigger,
  output logic [NUM_CH-1:0] zero_count_pulse,
  output logic int_n,
  input wire logic chain_enable_in,
  output logic chain_enable_out
);
  import ctc_pkg::*;

  if (NUM_CH != 4)
  begin : g_bad_width
    $error("counter_timer_unit serves exactly four channels");
  end

  logic io_sel_q;
  logic ack_q;
  logic fetch_q;
  logic prefix_q;
  logic [7:0] op_q;
  logic [7:0] vec_base_q;
  logic [NUM_CH-1:0] ip_q;
  logic [NUM_CH-1:0] ius_q;
  logic [NUM_CH-1:0] tc_expect_q;
  logic [NUM_CH-1:0] trg_q;
  logic [NUM_CH-1:0][7:0] ctrl_q;
  logic [NUM_CH-1:0][7:0] tc_q;
  logic [NUM_CH-1:0][7:0] cnt_q;
  logic [NUM_CH-1:0][7:0] pre_q;
  chan_state_t [NUM_CH-1:0] state_q;
  logic [NUM_CH-1:0] edge_hit;
  logic [NUM_CH-1:0] dec;
  logic [NUM_CH-1:0] zero_ev;
  logic [NUM_CH:0] chain;
  logic [NUM_CH-1:0] req;
  logic [NUM_CH-1:0] srv;
  logic [1:0] gid;

  wire [1:0] sel = {host_bus.channel_select_hi, host_bus.channel_select_lo};
  wire [7:0] din = host_bus.data;
  // Opcode fetch must be high, otherwise the cycle is an acknowledge.
  wire io_sel = !host_bus.io_request_n && !host_bus.chip_enable_n
                && host_bus.opcode_fetch_n;
  // No write strobe exists; a high read strobe marks the write.
  wire wr_take = io_sel && host_bus.read_n && !io_sel_q; // [R08] [R10]
  wire rd_take = io_sel && !host_bus.read_n && !io_sel_q;
  wire ack = !host_bus.opcode_fetch_n && !host_bus.io_request_n;
  wire ack_take = ack && !ack_q;
  wire fetch = !host_bus.opcode_fetch_n && !host_bus.read_n
               && host_bus.io_request_n;
  wire fetch_end = fetch_q && !fetch;
  wire return_from_interrupt_op_take = fetch_end && prefix_q && op_q == `OP_RETURN; // [R23]
  wire grant_any = ack_take && chain_enable_in && |req; // [R22]
  wire vec_wr = wr_take && sel == 2'h0 && !tc_expect_q[0]
                && !din[`CTL_VECTOR_BIT]; // [R05] [R06]
  wire [7:0] vector = {vec_base_q[`VEC_BASE_MSB:`VEC_BASE_LSB], gid,
                       1'b0}; // [R04] [R07]

  // A pending or in-service channel blocks every channel below it.
  always_comb
  begin
    chain[0] = chain_enable_in; // [R19]
    gid = 2'h0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      req[i] = ip_q[i] && !ius_q[i] && chain[i]; // [R20] [R21]
      srv[i] = ius_q[i] && chain[i];
      chain[i+1] = chain[i] && !ip_q[i] && !ius_q[i];
      if (req[i])
      begin
        gid = 2'(i);
      end
    end
  end

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    wire wr_me = wr_take && sel == 2'(i); // [R09]
    wire tc_wr = wr_me && tc_expect_q[i]; // [R01]
    wire ctl_wr = wr_me && !tc_expect_q[i]
                  && din[`CTL_VECTOR_BIT]; // [R24]
    wire counter = ctrl_q[i][`CTL_COUNTER];
    wire [7:0] pre_last = ctrl_q[i][`CTL_PRE256] ? `PRE256_LAST
                                                 : `PRE16_LAST;
    wire pre_tick = state_q[i] == CH_RUN && !counter
                    && pre_q[i] == pre_last;
    // Trigger pins are synchronous, so an edge close to the clock is
    // simply seen one sample later, which gives the one-clock slip.
    assign edge_hit[i] = (external_count_trigger[i] ^ trg_q[i])
      && external_count_trigger[i] == ctrl_q[i][`CTL_RISING]; // [R15]
    assign dec[i] = state_q[i] == CH_RUN
                    && (counter ? edge_hit[i] : pre_tick); // [R13]
    assign zero_ev[i] = dec[i] && cnt_q[i] == `BYTE_ONE;

    always_ff @(posedge core_clk or posedge reset)
    begin
      if (reset)
      begin
        state_q[i] <= CH_IDLE;
        ctrl_q[i] <= `BYTE_ZERO;
        tc_q[i] <= `BYTE_ZERO;
        cnt_q[i] <= `BYTE_ZERO;
        pre_q[i] <= `BYTE_ZERO;
        tc_expect_q[i] <= 1'b0;
        trg_q[i] <= 1'b0;
        zero_count_pulse[i] <= 1'b0;
      end
      else if (clk_en)
      begin
        trg_q[i] <= external_count_trigger[i];
        zero_count_pulse[i] <= zero_ev[i]; // [R16]
        if (ctl_wr)
        begin
          ctrl_q[i] <= din;
          tc_expect_q[i] <= din[`CTL_TC_FOLLOWS];
        end
        if (tc_wr)
        begin
          // A running channel keeps counting; the new value waits.
          tc_q[i] <= din; // [R01] [R03]
          tc_expect_q[i] <= 1'b0;
        end
        // Only a software-reset control word stops the counting below; other writes lose no tick.
        case (state_q[i])
          CH_IDLE:
          begin
            if (tc_wr)
            begin
              if (counter || !ctrl_q[i][`CTL_TRIGGERED])
              begin
                state_q[i] <= CH_RUN;
                cnt_q[i] <= din;
                pre_q[i] <= `BYTE_ZERO;
              end
              else
              begin
                state_q[i] <= CH_ARMED;
              end
            end
          end
          CH_ARMED:
          begin
            if (edge_hit[i])
            begin
              state_q[i] <= CH_START; // [R17]
            end
          end
          CH_START:
          begin
            state_q[i] <= CH_RUN; // [R17]
            cnt_q[i] <= tc_q[i];
            pre_q[i] <= `BYTE_ZERO;
          end
          CH_RUN:
          begin
            pre_q[i] <= pre_tick ? `BYTE_ZERO : pre_q[i] + 8'h01;
            if (zero_ev[i])
            begin
              cnt_q[i] <= tc_q[i]; // [R03]
            end
            else if (dec[i])
            begin
              // Zero wraps to 255, so a zero constant counts 256.
              cnt_q[i] <= cnt_q[i] - 8'h01; // [R02]
            end
          end
          default:
          begin
            state_q[i] <= CH_IDLE;
          end
        endcase
        // A software reset stops the channel whatever it was doing.
        if (ctl_wr && din[`CTL_SW_RESET])
        begin
          state_q[i] <= CH_IDLE;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      io_sel_q <= 1'b0;
      ack_q <= 1'b0;
      fetch_q <= 1'b0;
      prefix_q <= 1'b0;
      op_q <= `BYTE_ZERO;
      vec_base_q <= `BYTE_ZERO;
      ip_q <= '0;
      ius_q <= '0;
    end
    else if (clk_en)
    begin
      io_sel_q <= io_sel;
      ack_q <= ack;
      fetch_q <= fetch;
      if (fetch)
      begin
        op_q <= din;
      end
      if (fetch_end)
      begin
        prefix_q <= op_q == `OP_PREFIX;
      end
      if (vec_wr)
      begin
        vec_base_q <= din; // [R05] [R06]
      end
      // A new zero count wins over the clear by acknowledge.
      for (int i = 0; i < NUM_CH; i++)
      begin
        ip_q[i] <= (ip_q[i] && !(grant_any && req[i]))
                   || (zero_ev[i] && ctrl_q[i][`CTL_IRQ_EN]); // [R18]
        ius_q[i] <= (ius_q[i] && !(return_from_interrupt_op_take && srv[i]))
                    || (grant_any && req[i]); // [R21] [R23]
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      data_out <= `BYTE_ZERO;
      data_oe_n <= 1'b1;
      int_n <= 1'b1;
      chain_enable_out <= 1'b1;
    end
    else if (clk_en)
    begin
      if (rd_take)
      begin
        data_out <= cnt_q[sel]; // [R12]
      end
      else if (grant_any)
      begin
        data_out <= vector; // [R04] [R07] [R22]
      end
      data_oe_n <= !((io_sel && !host_bus.read_n)
                     || (ack && (ack_take ? grant_any : !data_oe_n)));
      // Request status is frozen while opcode fetch is low so the
      // chain can settle before the acknowledge.
      if (host_bus.opcode_fetch_n)
      begin
        int_n <= !(|req);
      end
      chain_enable_out <= chain[NUM_CH]; // [R19]
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset || !clk_en);

  a_tc_after_ctrl: assert property ( // [R01]
    wr_take && sel == 2'h1 && tc_expect_q[1]
    |=> tc_q[1] == $past(din) && !tc_expect_q[1])
    else $error("time constant not taken after control word");
  a_zero_means_256: assert property ( // [R02]
    dec[0] && cnt_q[0] == `BYTE_ZERO |=> cnt_q[0] == `BYTE_ALL)
    else $error("zero count did not wrap to 255");
  a_reload_at_zero: assert property ( // [R03]
    zero_ev[0] |=> cnt_q[0] == $past(tc_q[0]))
    else $error("counter not reloaded at zero");
  a_vector_bits: assert property ( // [R07]
    grant_any |=> data_out[2:1] == $past(gid) && !data_oe_n
    && data_out[7:3] == vec_base_q[7:3] && !data_out[0])
    else $error("vector bits wrong on acknowledge");
  a_vector_load: assert property ( // [R06]
    vec_wr |=> vec_base_q == $past(din))
    else $error("vector register not loaded");
  a_read_count: assert property ( // [R12]
    rd_take |=> data_out == $past(cnt_q[sel]) && !data_oe_n)
    else $error("read did not return the counter");
  a_zero_pulse: assert property ( // [R16]
    zero_ev[2] |=> zero_count_pulse[2])
    else $error("zero-count pulse missing");
  a_timer_start: assert property ( // [R17]
    state_q[0] == CH_ARMED && edge_hit[0] && !wr_take
    |=> state_q[0] == CH_START ##1 state_q[0] == CH_RUN)
    else $error("timer did not start on second edge");
  a_one_requester: assert property ( // [R20]
    $onehot0(req))
    else $error("more than one channel may request");
  a_ack_gated: assert property ( // [R22]
    ack_take && !chain_enable_in |=> data_oe_n)
    else $error("vector driven without chain enable");
  a_return_clears: assert property ( // [R23]
    return_from_interrupt_op_take && srv[1] |=> !ius_q[1])
    else $error("return did not end service");

  c_zero_irq: cover property (zero_ev[0] && ctrl_q[0][`CTL_IRQ_EN]);
  c_ack_grant: cover property (grant_any ##[1:40] return_from_interrupt_op_take);
  c_nested: cover property (ius_q[2] && grant_any && req[1]);
endmodule : counter_timer_unit

// ===== tb/host_cpu_model.sv
`timescale 1ns/10ps
module host_cpu_model (
  input wire logic core_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output ctc_pkg::host_bus_t bus
);
  import ctc_pkg::*;
  logic [7:0] rd_q;
  logic oe_q;
  initial bus = {4'b1111, 2'b00, 8'h00};
  // Released data lines flip so a stale byte can never pass for a fresh one.
  task automatic idle();
    bus <= {4'b1111, 2'b00, ~bus.data};
  endtask : idle
  task automatic wr(input logic [1:0] ch, input logic [7:0] d);
    @(posedge core_clk);
    bus <= {4'b0011, ch, d};
    @(posedge core_clk);
    idle();
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [1:0] ch);
    @(posedge core_clk);
    bus <= {4'b0001, ch, bus.data};
    @(posedge core_clk);
    #1;
    rd_q = data_out;
    oe_q = data_oe_n;
    @(posedge core_clk);
    idle();
    @(posedge core_clk);
  endtask : rd
  task automatic ack();
    @(posedge core_clk);
    bus <= {4'b1110, 2'b00, bus.data};
    repeat (2) @(posedge core_clk);
    bus.io_request_n <= 1'b0;
    @(posedge core_clk);
    #1;
    rd_q = data_out;
    oe_q = data_oe_n;
    @(posedge core_clk);
    idle();
    @(posedge core_clk);
  endtask : ack
  task automatic fetch(input logic [7:0] b);
    @(posedge core_clk);
    bus <= {4'b1100, 2'b00, b};
    @(posedge core_clk);
    @(posedge core_clk);
    idle();
    @(posedge core_clk);
  endtask : fetch
  task automatic return_from_interrupt_op();
    fetch(8'hed);
    fetch(8'h4d);
  endtask : return_from_interrupt_op
endmodule : host_cpu_model

// ===== tb/tb_counter_timer_unit.sv
`timescale 1ns/10ps
module tb_counter_timer_unit;
  import ctc_pkg::*;
  logic core_clk;
  logic reset;
  logic clk_en;
  logic chain_enable_in;
  logic [3:0] trig;
  logic [3:0] zcp;
  logic [7:0] data_out;
  logic data_oe_n;
  logic int_n;
  logic chain_enable_out;
  host_bus_t host_bus;
  int failures;
  int samples_checked;
  int cycles;
  int zc_seen [4];
  counter_timer_unit counter_timer_unit_i (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .host_bus(host_bus),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .external_count_trigger(trig),
    .zero_count_pulse(zcp),
    .int_n(int_n),
    .chain_enable_in(chain_enable_in),
    .chain_enable_out(chain_enable_out)
  );
  host_cpu_model host_cpu_model_i (
    .core_clk(core_clk),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .bus(host_bus)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // The whole sequence needs well under two thousand cycles.
  always @(posedge core_clk)
  begin
    cycles++;
    for (int i = 0; i < 4; i++)
      if (zcp[i] === 1'b1)
        zc_seen[i]++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  // Pulses stay two clocks wide and at least three clocks apart.
  task automatic pulse(input int ch);
    @(posedge core_clk);
    trig[ch] <= 1'b1;
    repeat (2) @(posedge core_clk);
    trig[ch] <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse
  task automatic rd_chk(input logic [1:0] ch, input logic [7:0] exp);
    host_cpu_model_i.rd(ch);
    check({7'h00, host_cpu_model_i.oe_q}, 8'h00);
    check(host_cpu_model_i.rd_q, exp);
  endtask : rd_chk
  task automatic ack_chk(input logic [7:0] exp);
    host_cpu_model_i.ack();
    check({7'h00, host_cpu_model_i.oe_q}, 8'h00);
    check(host_cpu_model_i.rd_q, exp);
  endtask : ack_chk
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    chain_enable_in = 1'b1;
    trig = 4'h0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check({1'b0, data_oe_n, int_n, chain_enable_out, zcp}, 8'h70);
    host_cpu_model_i.wr(2'd0, 8'ha8);
    host_cpu_model_i.wr(2'd1, 8'h50);
    host_cpu_model_i.wr(2'd1, 8'hd5);
    host_cpu_model_i.wr(2'd1, 8'h03);
    rd_chk(2'd1, 8'h03);
    pulse(1);
    pulse(1);
    rd_chk(2'd1, 8'h01);
    host_cpu_model_i.wr(2'd1, 8'hd5);
    host_cpu_model_i.wr(2'd1, 8'h05);
    rd_chk(2'd1, 8'h01);
    pulse(1);
    rd_chk(2'd1, 8'h05);
    check(8'(zc_seen[1]), 8'h01);
    check({7'h00, int_n}, 8'h00);
    chain_enable_in <= 1'b0;
    host_cpu_model_i.ack();
    check({7'h00, host_cpu_model_i.oe_q}, 8'h01);
    chain_enable_in <= 1'b1;
    ack_chk(8'haa);
    check({7'h00, chain_enable_out}, 8'h00);
    host_cpu_model_i.return_from_interrupt_op();
    // The chain output is registered, so it follows the return one clock late.
    repeat (2) @(posedge core_clk);
    check({6'h00, int_n, chain_enable_out}, 8'h03);
    host_cpu_model_i.wr(2'd0, 8'h55);
    host_cpu_model_i.wr(2'd0, 8'h00);
    pulse(0);
    rd_chk(2'd0, 8'hff);
    // A frozen block ignores the pulse, so the count must not move.
    clk_en <= 1'b0;
    pulse(0);
    clk_en <= 1'b1;
    rd_chk(2'd0, 8'hff);
    // Triggered timer, long prescaler: the first step lands 256 clocks after the start.
    host_cpu_model_i.wr(2'd0, 8'h3f);
    host_cpu_model_i.wr(2'd0, 8'h02);
    pulse(0);
    rd_chk(2'd0, 8'h02);
    // The read is taken one clock after the step, so a slipped start shows.
    repeat (249) @(posedge core_clk);
    rd_chk(2'd0, 8'h01);
    host_cpu_model_i.wr(2'd3, 8'hd5);
    host_cpu_model_i.wr(2'd3, 8'h01);
    pulse(3);
    host_cpu_model_i.wr(2'd2, 8'h85);
    host_cpu_model_i.wr(2'd2, 8'h01);
    repeat (40) @(posedge core_clk);
    // Stopping the timer keeps its request but ends further zero counts.
    host_cpu_model_i.wr(2'd2, 8'h03);
    check(8'(zc_seen[2]), 8'h02);
    ack_chk(8'hac);
    repeat (2) @(posedge core_clk);
    check({7'h00, int_n}, 8'h01);
    host_cpu_model_i.return_from_interrupt_op();
    repeat (2) @(posedge core_clk);
    check({7'h00, int_n}, 8'h00);
    ack_chk(8'hae);
    host_cpu_model_i.return_from_interrupt_op();
    repeat (2) @(posedge core_clk);
    check({6'h00, int_n, chain_enable_out}, 8'h03);
    end_of_test();
  end
endmodule : tb_counter_timer_unit
